// >>> verilog/rnc_pkg.sv
// shared constants and types for the nibble-bus calendar clock core
package rnc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register addresses
    localparam logic [3:0] ADR_SEC_U   = 4'h0;
    localparam logic [3:0] ADR_SEC_T   = 4'h1;
    localparam logic [3:0] ADR_MIN_U   = 4'h2;
    localparam logic [3:0] ADR_MIN_T   = 4'h3;
    localparam logic [3:0] ADR_HOUR_U  = 4'h4;
    localparam logic [3:0] ADR_HOUR_T  = 4'h5;
    localparam logic [3:0] ADR_DATE_U  = 4'h6;
    localparam logic [3:0] ADR_DATE_T  = 4'h7;
    localparam logic [3:0] ADR_MON_U   = 4'h8;
    localparam logic [3:0] ADR_MON_T   = 4'h9;
    localparam logic [3:0] ADR_YEAR_U  = 4'hA;
    localparam logic [3:0] ADR_YEAR_T  = 4'hB;
    localparam logic [3:0] ADR_WDAY    = 4'hC;
    localparam logic [3:0] ADR_TSEL    = 4'hD;
    localparam logic [3:0] ADR_KEY     = 4'hE;
    localparam logic [3:0] ADR_STATUS  = 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // field positions and key value
    localparam int LEAP_HI_BIT = 3;
    localparam int LEAP_LO_BIT = 2;
    localparam int LEAP_IND_BIT = 1;
    localparam int BUSY_BIT = 1;
    localparam int XBUSY_BIT = 0;
    localparam logic [3:0] KEY_OPEN = 4'h5;

    ////////////////////////////////////////////////////////////////////////////
    // counting limits, bcd
    localparam logic [7:0] SEC_MAX    = 8'h59;
    localparam logic [7:0] SEC_HALF   = 8'h30;
    localparam logic [7:0] MIN_MAX    = 8'h59;
    localparam logic [7:0] HOUR_MAX   = 8'h23;
    localparam logic [7:0] MON_MAX    = 8'h12;
    localparam logic [7:0] YEAR_MAX   = 8'h99;
    localparam logic [2:0] WDAY_MAX   = 3'h6;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [7:0] RST_SEC    = 8'h00;
    localparam logic [7:0] RST_MIN    = 8'h00;
    localparam logic [7:0] RST_HOUR   = 8'h00;
    localparam logic [7:0] RST_DATE   = 8'h01;
    localparam logic [7:0] RST_MON    = 8'h01;
    localparam logic [7:0] RST_YEAR   = 8'h00;
    localparam logic [2:0] RST_WDAY   = 3'h0;
    localparam logic [3:0] RST_TSEL   = 4'hF;
    localparam logic [3:0] RST_KEY    = 4'h0;
    localparam logic [1:0] RST_LEAP   = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // crystal division and tick selections
    localparam int XTAL_HZ = 32768;
    localparam int DIV_W = 15;
    localparam int EIGHTH_BIT = 2;
    localparam int ONE_HZ_BIT = 14;
    localparam logic [3:0] TSEL_LAST_WAVE = 4'hB;
    localparam logic [3:0] TSEL_MIN_PULSE = 4'hC;
    localparam logic [3:0] TSEL_TENMIN_PULSE = 4'hD;
    localparam logic [3:0] TSEL_HIGH = 4'hE;
    localparam logic [3:0] TSEL_LOW = 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // host pin bundle as seen after synchronising
    typedef struct packed {
        logic ale;
        logic cs;
        logic wr_rd;
        logic [3:0] nibble_bus;
    } rnc_pins_t;

endpackage : rnc_pkg

// >>> verilog/rnc_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module rnc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

endmodule : rnc_sync

// >>> verilog/rnc_tickgen.sv
// crystal divider, eighth-rate output and programmable tick output
`timescale 1ns/10ps
module rnc_tickgen (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // crystal level, already synchronised
    input wire logic xtal_s,
    // control
    input wire logic [3:0] tsel,
    input wire logic min_req,
    input wire logic tenmin_req,
    // events
    output logic xt_tick,
    output logic sec_tick,
    // outputs
    output logic eighth_crystal_out,
    output logic tick_out
);

    logic xtal_d_r;
    logic [rnc_pkg::DIV_W-1:0] div_r;
    logic min_pulse_r;
    logic tenmin_pulse_r;
    logic tick_r;

    assign xt_tick = xtal_s & ~xtal_d_r;
    assign sec_tick = xt_tick & (&div_r);
    assign eighth_crystal_out = div_r[rnc_pkg::EIGHTH_BIT]; // [RL15]
    assign tick_out = tick_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            xtal_d_r <= 1'b0;
            div_r <= '0;
        end else begin
            xtal_d_r <= xtal_s;
            if (xt_tick) begin
                div_r <= div_r + 1'b1; // [RL15] [RL20]
            end
        end
    end

    // one crystal period wide pulses, set wins over end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            min_pulse_r <= 1'b0;
            tenmin_pulse_r <= 1'b0;
        end else begin
            min_pulse_r <= min_req | (min_pulse_r & ~xt_tick); // [RL17]
            tenmin_pulse_r <= tenmin_req | (tenmin_pulse_r & ~xt_tick); // [RL17]
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tick_r <= 1'b0;
        end else begin
            if (tsel <= rnc_pkg::TSEL_LAST_WAVE) begin
                tick_r <= div_r[4'(rnc_pkg::ONE_HZ_BIT) - tsel]; // [RL17]
            end else if (tsel == rnc_pkg::TSEL_MIN_PULSE) begin
                tick_r <= min_pulse_r; // [RL17]
            end else if (tsel == rnc_pkg::TSEL_TENMIN_PULSE) begin
                tick_r <= tenmin_pulse_r; // [RL17]
            end else begin
                tick_r <= (tsel == rnc_pkg::TSEL_HIGH); // [RL17]
            end
        end
    end

endmodule : rnc_tickgen

// >>> verilog/rnc_core.sv
// calendar clock core with nibble-wide multiplexed host port
// Behaviour
// RL1: while address strobe is high, bus nibble loads the address latch
// RL2: host latches address first, then raises chip select with direction set
// RL3: chip select and write high store the bus nibble to latched register
// RL4: chip select high with write low drives the selected nibble out
// RL5: with chip select low the bus is released as input
// RL6: sixteen registers decoded from the four-bit latched address
// RL7: bcd pairs from 0 to B, weekday C, tick D, key E, status F
// RL8: unused bits ignored on write and read back as zero
// RL9: weekday counts 0 to 6, advancing once per day
// RL10: only the key is writable unless the key holds five
// RL11: host writes five to the key before other writes
// RL12: supply failure clears the key
// RL13: address F reads busy on bit 1 and count-seen on bit 0
// RL14: host uses status flags to avoid the per-second count
// RL15: free-running half-duty output at one eighth of crystal rate
// RL16: month-tens high bits set leap phase; leap indicator reads on bit 1
// RL17: tick select picks waves, minute pulses, or fixed levels
// RL18: status write zeroes seconds, carrying into minutes above thirty
// RL19: count-seen set by busy, cleared at status read trailing edge
// RL20: bcd counters advance once per second with correct month lengths
`timescale 1ns/10ps
module rnc_core (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // crystal and supply monitor
    input wire logic xtal_in,
    input wire logic supply_fail,
    // host port
    input wire logic ale,
    input wire logic cs,
    input wire logic wr_rd,
    input wire logic [3:0] nibble_bus_in,
    output logic [3:0] nibble_bus_out,
    output logic nibble_bus_oe_n,
    // signal outputs
    output logic eighth_crystal_out,
    output logic tick_out
);

    ////////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (v[3:0] == 4'h9) begin
            r = {4'(v[7:4] + 4'h1), 4'h0};
        end else begin
            r = {v[7:4], 4'(v[3:0] + 4'h1)};
        end
        return r;
    endfunction : bcd_inc

    function automatic logic [7:0] month_days(input logic [7:0] mon, input logic leap);
        logic [7:0] d;
        d = 8'h31;
        if (mon == 8'h02) begin
            d = leap ? 8'h29 : 8'h28;
        end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
            d = 8'h30;
        end
        return d;
    endfunction : month_days

    ////////////////////////////////////////////////////////////////////////////
    // synchronised pins

    rnc_pkg::rnc_pins_t pins_raw;
    rnc_pkg::rnc_pins_t pins_s;
    logic xtal_s;
    logic fail_s;

    assign pins_raw = '{ale: ale, cs: cs, wr_rd: wr_rd, nibble_bus: nibble_bus_in};

    rnc_sync #(.W($bits(rnc_pkg::rnc_pins_t))) u_sync_host (
        .mclk(mclk),
        .arst_n(arst_n),
        .din(pins_raw),
        .dout(pins_s)
    );

    rnc_sync #(.W(2)) u_sync_misc (
        .mclk(mclk),
        .arst_n(arst_n),
        .din({xtal_in, supply_fail}),
        .dout({xtal_s, fail_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [3:0] addr_r;
    logic wr_d_r;
    logic rd_stat_d_r;
    logic [7:0] sec_r;
    logic [7:0] min_r;
    logic [7:0] hour_r;
    logic [7:0] date_r;
    logic [7:0] mon_r;
    logic [7:0] year_r;
    logic [1:0] leap_r;
    logic [2:0] wday_r;
    logic [3:0] tsel_r;
    logic [3:0] key_r;
    logic busy_r;
    logic xbusy_r;
    logic [3:0] rd_r;

    logic xt_tick;
    logic sec_tick;
    logic wr_lvl;
    logic wr_start;
    logic wr_ok;
    logic [3:0] wd;
    logic rd_stat;
    logic sec_clear;
    logic clear_carry;
    logic carry_min;
    logic carry_hour;
    logic carry_day;
    logic carry_mon;
    logic carry_year;
    logic is_leap;
    logic [1:0] year_mod4;
    logic busy_set;

    ////////////////////////////////////////////////////////////////////////////
    // host port decode

    assign wd = pins_s.nibble_bus;
    assign wr_lvl = pins_s.cs & pins_s.wr_rd;
    assign wr_start = wr_lvl & ~wr_d_r; // [RL3]
    assign wr_ok = wr_start & ((key_r == rnc_pkg::KEY_OPEN) | (addr_r == rnc_pkg::ADR_KEY)); // [RL10]
    assign rd_stat = pins_s.cs & ~pins_s.wr_rd & (addr_r == rnc_pkg::ADR_STATUS);
    assign nibble_bus_oe_n = ~(pins_s.cs & ~pins_s.wr_rd); // [RL4] [RL5]
    assign nibble_bus_out = rd_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            addr_r <= 4'h0;
        end else if (pins_s.ale) begin
            addr_r <= pins_s.nibble_bus; // [RL1]
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_d_r <= 1'b0;
            rd_stat_d_r <= 1'b0;
        end else begin
            wr_d_r <= wr_lvl;
            rd_stat_d_r <= rd_stat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // carries and leap year

    assign sec_clear = wr_ok & (addr_r == rnc_pkg::ADR_STATUS); // [RL18]
    assign clear_carry = sec_clear & (sec_r > rnc_pkg::SEC_HALF); // [RL18]
    assign carry_min = (sec_tick & (sec_r == rnc_pkg::SEC_MAX)) | clear_carry; // [RL20]
    assign carry_hour = carry_min & (min_r == rnc_pkg::MIN_MAX);
    assign carry_day = carry_hour & (hour_r == rnc_pkg::HOUR_MAX);
    assign carry_mon = carry_day & (date_r == month_days(mon_r, is_leap)); // [RL20]
    assign carry_year = carry_mon & (mon_r == rnc_pkg::MON_MAX);
    assign year_mod4 = {year_r[4] ^ year_r[1], year_r[0]};
    assign is_leap = (year_mod4 == leap_r); // [RL16]
    assign busy_set = sec_tick | clear_carry; // [RL18]

    ////////////////////////////////////////////////////////////////////////////
    // seconds and minutes

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sec_r <= rnc_pkg::RST_SEC;
        end else if (wr_ok && addr_r == rnc_pkg::ADR_SEC_U) begin
            sec_r[3:0] <= wd; // [RL3] [RL7]
        end else if (wr_ok && addr_r == rnc_pkg::ADR_SEC_T) begin
            sec_r[7:4] <= {1'b0, wd[2:0]}; // [RL8]
        end else if (sec_clear) begin
            sec_r <= 8'h00; // [RL18]
        end else if (sec_tick) begin
            sec_r <= (sec_r == rnc_pkg::SEC_MAX) ? 8'h00 : bcd_inc(sec_r); // [RL20]
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            min_r <= rnc_pkg::RST_MIN;
        end else if (wr_ok && addr_r == rnc_pkg::ADR_MIN_U) begin
            min_r[3:0] <= wd;
        end else if (wr_ok && addr_r == rnc_pkg::ADR_MIN_T) begin
            min_r[7:4] <= {1'b0, wd[2:0]}; // [RL8]
        end else if (carry_min) begin
            min_r <= (min_r == rnc_pkg::MIN_MAX) ? 8'h00 : bcd_inc(min_r); // [RL20]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // hours, date and weekday

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hour_r <= rnc_pkg::RST_HOUR;
        end else if (wr_ok && addr_r == rnc_pkg::ADR_HOUR_U) begin
            hour_r[3:0] <= wd;
        end else if (wr_ok && addr_r == rnc_pkg::ADR_HOUR_T) begin
            hour_r[7:4] <= {2'b00, wd[1:0]}; // [RL8]
        end else if (carry_hour) begin
            hour_r <= (hour_r == rnc_pkg::HOUR_MAX) ? 8'h00 : bcd_inc(hour_r); // [RL20]
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            date_r <= rnc_pkg::RST_DATE;
        end else if (wr_ok && addr_r == rnc_pkg::ADR_DATE_U) begin
            date_r[3:0] <= wd;
        end else if (wr_ok && addr_r == rnc_pkg::ADR_DATE_T) begin
            date_r[7:4] <= {2'b00, wd[1:0]}; // [RL8]
        end else if (carry_day) begin
            date_r <= carry_mon ? 8'h01 : bcd_inc(date_r); // [RL20]
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wday_r <= rnc_pkg::RST_WDAY;
        end else if (wr_ok && addr_r == rnc_pkg::ADR_WDAY) begin
            wday_r <= wd[2:0]; // [RL8] [RL9]
        end else if (carry_day) begin
            wday_r <= (wday_r >= rnc_pkg::WDAY_MAX) ? 3'h0 : 3'(wday_r + 3'h1); // [RL9]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // month, leap phase and year

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mon_r <= rnc_pkg::RST_MON;
            leap_r <= rnc_pkg::RST_LEAP;
        end else if (wr_ok && addr_r == rnc_pkg::ADR_MON_U) begin
            mon_r[3:0] <= wd;
        end else if (wr_ok && addr_r == rnc_pkg::ADR_MON_T) begin
            mon_r[7:4] <= {3'b000, wd[0]}; // [RL8]
            leap_r <= {wd[rnc_pkg::LEAP_HI_BIT], wd[rnc_pkg::LEAP_LO_BIT]}; // [RL16]
        end else if (carry_mon) begin
            mon_r <= carry_year ? 8'h01 : bcd_inc(mon_r); // [RL20]
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            year_r <= rnc_pkg::RST_YEAR;
        end else if (wr_ok && addr_r == rnc_pkg::ADR_YEAR_U) begin
            year_r[3:0] <= wd;
        end else if (wr_ok && addr_r == rnc_pkg::ADR_YEAR_T) begin
            year_r[7:4] <= wd;
        end else if (carry_year) begin
            year_r <= (year_r == rnc_pkg::YEAR_MAX) ? 8'h00 : bcd_inc(year_r); // [RL20]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // tick select and protect key

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tsel_r <= rnc_pkg::RST_TSEL;
        end else if (wr_ok && addr_r == rnc_pkg::ADR_TSEL) begin
            tsel_r <= wd; // [RL17]
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            key_r <= rnc_pkg::RST_KEY;
        end else if (fail_s) begin
            key_r <= rnc_pkg::RST_KEY; // [RL12]
        end else if (wr_ok && addr_r == rnc_pkg::ADR_KEY) begin
            key_r <= wd; // [RL10]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // busy pulse and count-seen flag

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= busy_set | (busy_r & ~xt_tick); // [RL13] [RL18]
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            xbusy_r <= 1'b0;
        end else if (busy_set) begin
            xbusy_r <= 1'b1; // [RL19]
        end else if (rd_stat_d_r && !rd_stat) begin
            xbusy_r <= 1'b0; // [RL19]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_r <= 4'h0;
        end else begin
            unique case (addr_r) // [RL6] [RL7]
                rnc_pkg::ADR_SEC_U: rd_r <= sec_r[3:0];
                rnc_pkg::ADR_SEC_T: rd_r <= {1'b0, sec_r[6:4]}; // [RL8]
                rnc_pkg::ADR_MIN_U: rd_r <= min_r[3:0];
                rnc_pkg::ADR_MIN_T: rd_r <= {1'b0, min_r[6:4]};
                rnc_pkg::ADR_HOUR_U: rd_r <= hour_r[3:0];
                rnc_pkg::ADR_HOUR_T: rd_r <= {2'b00, hour_r[5:4]};
                rnc_pkg::ADR_DATE_U: rd_r <= date_r[3:0];
                rnc_pkg::ADR_DATE_T: rd_r <= {2'b00, date_r[5:4]};
                rnc_pkg::ADR_MON_U: rd_r <= mon_r[3:0];
                rnc_pkg::ADR_MON_T: rd_r <= {leap_r, is_leap, mon_r[4]}; // [RL16]
                rnc_pkg::ADR_YEAR_U: rd_r <= year_r[3:0];
                rnc_pkg::ADR_YEAR_T: rd_r <= year_r[7:4];
                rnc_pkg::ADR_WDAY: rd_r <= {1'b0, wday_r}; // [RL8]
                rnc_pkg::ADR_TSEL: rd_r <= tsel_r;
                rnc_pkg::ADR_KEY: rd_r <= 4'h0; // [RL8]
                rnc_pkg::ADR_STATUS: rd_r <= {2'b00, busy_r, xbusy_r}; // [RL13]
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // crystal divider and tick output

    rnc_tickgen u_tickgen (
        .mclk(mclk),
        .arst_n(arst_n),
        .xtal_s(xtal_s),
        .tsel(tsel_r),
        .min_req(carry_min),
        .tenmin_req(carry_min & (min_r[3:0] == 4'h9)),
        .xt_tick(xt_tick),
        .sec_tick(sec_tick),
        .eighth_crystal_out(eighth_crystal_out),
        .tick_out(tick_out)
    );

endmodule : rnc_core

// >>> testbench/rnc_core_properties.sv
// checker for the calendar clock core pins
`timescale 1ns/10ps
module rnc_core_properties (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // host port
    input wire logic ale,
    input wire logic cs,
    input wire logic wr_rd,
    input wire logic [3:0] nibble_bus_in,
    input wire logic [3:0] nibble_bus_out,
    input wire logic nibble_bus_oe_n,
    // outputs
    input wire logic eighth_crystal_out,
    input wire logic tick_out
);
    ////////////////////////////////////////////////////////////////////////////
    // shadow of the synced address latch
    logic [4:0] d1_r;
    logic [4:0] d2_r;
    logic [3:0] adr_r;
    logic [1:0] up_r;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            d1_r <= 5'h00;
            d2_r <= 5'h00;
            up_r <= 2'h0;
        end else begin
            d1_r <= {ale, nibble_bus_in};
            d2_r <= d1_r;
            up_r <= up_r[1] ? up_r : up_r + 2'h1;
        end
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            adr_r <= 4'h0;
        end else if (d2_r[4]) begin
            adr_r <= d2_r[3:0];
        end
    end
    function automatic logic [3:0] dead_bits(input logic [3:0] a);
        case (a)
            4'h1, 4'h3, 4'hC: dead_bits = 4'h8;
            4'h5, 4'h7: dead_bits = 4'hC;
            default: dead_bits = 4'h0;
        endcase
    endfunction : dead_bits
    ////////////////////////////////////////////////////////////////////////////
    // properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_oe_follow;
        up_r[1] |-> nibble_bus_oe_n == !($past(cs, 2) && !$past(wr_rd, 2));
    endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("bus enable off its pins");
    property p_oe_idle; !cs [*3] |-> nibble_bus_oe_n; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("bus driven while idle");
    property p_wr_release; wr_rd [*3] |-> nibble_bus_oe_n; endproperty
    a_wr_release: assert property (p_wr_release) else $error("bus driven in write");
    property p_dead_zero; (nibble_bus_out & dead_bits($past(adr_r))) == 4'h0; endproperty
    a_dead_zero: assert property (p_dead_zero) else $error("unused bit read high");
    property p_key_zero; $past(adr_r) == 4'hE |-> nibble_bus_out == 4'h0; endproperty
    a_key_zero: assert property (p_key_zero) else $error("key read not zero");
    property p_status_hi; $past(adr_r) == 4'hF |-> nibble_bus_out[3:2] == 2'h0; endproperty
    a_status_hi: assert property (p_status_hi) else $error("status high bits set");
    property p_eighth_hi;
        $rose(eighth_crystal_out) |-> eighth_crystal_out [*8] ##1 !eighth_crystal_out;
    endproperty
    a_eighth_hi: assert property (p_eighth_hi) else $error("eighth high phase length");
    property p_eighth_lo;
        $fell(eighth_crystal_out) |-> !eighth_crystal_out [*8] ##1 eighth_crystal_out;
    endproperty
    a_eighth_lo: assert property (p_eighth_lo) else $error("eighth low phase length");
    cover property (!nibble_bus_oe_n);
    cover property ($past(adr_r) == 4'hF && nibble_bus_out[0]);
    cover property ($rose(tick_out));
endmodule : rnc_core_properties

// >>> testbench/rnc_host_model.sv
// host processor model for the nibble bus port
`timescale 1ns/10ps
module rnc_host_model (
    // clock
    input wire logic mclk,
    // host pins
    output logic ale,
    output logic cs,
    output logic wr_rd,
    output logic drv_en,
    output logic [3:0] drv_bus,
    // device answer
    input wire logic [3:0] rd_bus,
    input wire logic oe_n
);
    initial begin
        ale = 1'b0;
        cs = 1'b0;
        wr_rd = 1'b0;
        drv_en = 1'b0;
        drv_bus = 4'h0;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask : idle
    // address first, strobe dropped with address still held
    task automatic put_adr(input logic [3:0] a);
        drv_en = 1'b1;
        drv_bus = a;
        ale = 1'b1;
        idle(3);
        ale = 1'b0;
        idle(3);
    endtask : put_adr
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        put_adr(a);
        drv_bus = d;
        idle(1);
        wr_rd = 1'b1;
        cs = 1'b1;
        idle(4);
        cs = 1'b0;
        idle(3);
        wr_rd = 1'b0;
        drv_en = 1'b0;
        idle(2);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [3:0] d, output logic ok);
        int n;
        put_adr(a);
        drv_en = 1'b0;
        cs = 1'b1;
        n = 0;
        while (oe_n !== 1'b0 && n < 8) begin
            idle(1);
            n++;
        end
        ok = (oe_n === 1'b0);
        idle(2);
        d = rd_bus;
        cs = 1'b0;
        idle(3);
    endtask : rd
endmodule : rnc_host_model

// >>> testbench/rnc_core_tb.sv
// self-checking bench for the calendar clock core
`timescale 1ns/10ps
module rnc_core_tb;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic xtal_in = 1'b0;
    logic supply_fail = 1'b0;
    logic ale, cs, wr_rd, drv_en, oe_n, eighth, tick;
    logic [3:0] drv_bus, bus_in, bus_out;
    int fail_count = 0;
    int cmp_count = 0;
    int hi_n = 0;
    always #4 mclk = ~mclk;
    always @(negedge mclk) xtal_in <= ~xtal_in;
    always @(negedge mclk) hi_n <= hi_n + int'(tick);
    // pulled-down bus, device wins while driving
    assign bus_in = !oe_n ? bus_out : (drv_en ? drv_bus : 4'h0);
    rnc_core DUT (.mclk(mclk), .arst_n(arst_n), .xtal_in(xtal_in), .supply_fail(supply_fail),
        .ale(ale), .cs(cs), .wr_rd(wr_rd), .nibble_bus_in(bus_in), .nibble_bus_out(bus_out),
        .nibble_bus_oe_n(oe_n), .eighth_crystal_out(eighth), .tick_out(tick));
    rnc_host_model host (.mclk(mclk), .ale(ale), .cs(cs), .wr_rd(wr_rd), .drv_en(drv_en),
        .drv_bus(drv_bus), .rd_bus(bus_out), .oe_n(oe_n));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic rd_exp(input logic [3:0] a, input logic [3:0] exp);
        logic [3:0] d;
        logic ok;
        host.rd(a, d, ok);
        if (!ok) begin
            fail_count++;
            report_and_stop();
        end else begin
            check(d, exp);
        end
    endtask : rd_exp
    task automatic load(input logic [55:0] v);
        for (int i = 0; i < 14; i++) begin
            host.wr(4'(i), v[4*i +: 4]);
        end
    endtask : load
    task automatic expect_all(input logic [55:0] v);
        for (int i = 0; i < 14; i++) begin
            rd_exp(4'(i), v[4*i +: 4]);
        end
    endtask : expect_all
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [3:0] cnt;
        logic prev;
        int k;
        repeat (4) @(negedge mclk);
        arst_n = 1'b1;
        host.idle(2);
        expect_all(56'hF0002101000000);
        rd_exp(4'hE, 4'h0);
        rd_exp(4'hF, 4'h0);
        $display("test reset map done");
        host.wr(4'h0, 4'h7);
        rd_exp(4'h0, 4'h0);
        host.wr(4'hE, 4'h5);
        host.wr(4'h0, 4'h7);
        host.wr(4'h1, 4'hC);
        rd_exp(4'h0, 4'h7);
        rd_exp(4'h1, 4'h4);
        $display("test protect key done");
        load(56'hF6040228235945);
        host.wr(4'hF, 4'h0);
        expect_all(56'hF0042229000000);
        rd_exp(4'hF, 4'h1);
        rd_exp(4'hF, 4'h0);
        load(56'hF6050228235945);
        host.wr(4'hF, 4'h0);
        expect_all(56'hF0050301000000);
        rd_exp(4'hF, 4'h1);
        host.wr(4'h9, 4'h4);
        rd_exp(4'h9, 4'h6);
        host.wr(4'h1, 4'h3);
        host.wr(4'hF, 4'h0);
        rd_exp(4'hF, 4'h0);
        rd_exp(4'h0, 4'h0);
        rd_exp(4'h2, 4'h0);
        $display("test second reset and calendar done");
        for (int s = 0; s < 16; s++) begin
            host.wr(4'hD, 4'(s));
            host.idle(8);
            cnt = 4'h0;
            prev = tick;
            repeat (64) begin
                host.idle(1);
                cnt = cnt + 4'(tick !== prev);
                prev = tick;
            end
            if (s >= 9) check(cnt, (s > 11) ? 4'h0 : 4'(1 << (s - 9)));
            if (s >= 12) check({3'h0, tick}, {3'h0, s == 14});
        end
        host.wr(4'hD, 4'hD);
        host.wr(4'h2, 4'h9);
        host.wr(4'h1, 4'h5);
        k = hi_n;
        host.wr(4'hF, 4'h0);
        check(4'(hi_n > k), 4'h1);
        rd_exp(4'h3, 4'h1);
        $display("test tick select done");
        supply_fail = 1'b1;
        host.idle(4);
        supply_fail = 1'b0;
        host.idle(4);
        host.wr(4'h0, 4'h3);
        rd_exp(4'h0, 4'h0);
        $display("test supply fail done");
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        report_and_stop();
    end
endmodule : rnc_core_tb
bind rnc_core rnc_core_properties chk (.mclk(mclk), .arst_n(arst_n), .ale(ale), .cs(cs),
    .wr_rd(wr_rd), .nibble_bus_in(nibble_bus_in), .nibble_bus_out(nibble_bus_out),
    .nibble_bus_oe_n(nibble_bus_oe_n), .eighth_crystal_out(eighth_crystal_out),
    .tick_out(tick_out));
